//--- inc/sar_adc_map.vh
// register map, field positions, reset values and timing counts of the converter control
// How it works
// - config fields of the second control register and slot registers change only while conversion enable is 0; multi-sample bit 7 changes at any time
// - conversion clock source bits 4-3: oscillator, auxiliary, main, sub-main clock
// - sequence mode bits 2-1: single, sequence, repeat single, repeat sequence
// - busy bit 0 reads 1 while a sequence, sample or conversion is active
// - sample input invert bit 8 inverts the selected trigger signal when set
// - results are 12 bits right-justified, bits 15-12 read zero
// - software start bit clears itself once acted on; may be set with enable
// - multi-sample mode: first trigger edge starts, later conversions follow automatically
// - slot result flag sets on result load, clears when that result word is accessed
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH

// byte offsets on the register bus
`define OFS_CTL0         8'h00
`define OFS_CTL1         8'h04
`define OFS_FLAGS        8'h08
`define OFS_MASK         8'h0C
`define OFS_SLOT_BASE    8'h40
`define OFS_RESULT_BASE  8'h80

// first control register fields
`define CTL0_START       0
`define CTL0_ENABLE      1
`define CTL0_MSC         7

// second control register fields
`define CTL1_BUSY        0
`define CTL1_MODE_LO     1
`define CTL1_MODE_HI     2
`define CTL1_CSRC_LO     3
`define CTL1_CSRC_HI     4
`define CTL1_DIV_LO      5
`define CTL1_DIV_HI      7
`define CTL1_INVERT      8
`define CTL1_PULSE       9
`define CTL1_TSRC_LO     10
`define CTL1_TSRC_HI     11
`define CTL1_FIRST_LO    12
`define CTL1_FIRST_HI    15

// slot control fields
`define SLOT_CH_LO       0
`define SLOT_CH_HI       3
`define SLOT_REF_LO      4
`define SLOT_REF_HI      6
`define SLOT_EOS         7

// encodings
`define MODE_SINGLE      2'b00
`define MODE_SEQ         2'b01
`define MODE_REP_SINGLE  2'b10
`define MODE_REP_SEQ     2'b11
`define CSRC_OSC         2'b00
`define CSRC_AUX         2'b01
`define CSRC_MAIN        2'b10
`define CSRC_SUB         2'b11
`define TSRC_SOFT        2'b00
`define TSRC_TIMER_A     2'b01
`define TSRC_TIMER_B     2'b10

// reset values
`define CTL0_RESET       8'h00
`define CTL1_RESET       16'h0000
`define SLOT_RESET       8'h00

// sampling period in conversion clock ticks when the sampling timer is used
`define SAMPLE_TICKS     4'h4

`endif

//--- logic/result_store.v
// sixteen-word result memory with registered read data
module result_store (
   // clock and reset
   input  wire        mclk,
   input  wire        nrst,
   // write port
   input  wire        we,
   input  wire [3:0]  waddr,
   input  wire [11:0] wdata,
   // read port
   input  wire        re,
   input  wire [3:0]  raddr,
   output reg  [11:0] rdata_q
);

   reg [11:0] mem [0:15];

   // contents are unchanged by reset, only the read register clears
   always @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 12'h000;
      end else if (re) begin
         rdata_q <= mem[raddr];
      end
   end

endmodule // result_store

//--- logic/sar_adc_sequence_control.v
// sequence control, configuration registers and result storage of the sar converter
`include "sar_adc_map.vh"

module sar_adc_sequence_control (
   // clock and reset
   input  wire        mclk,
   input  wire        nrst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // trigger pins from the timers
   input  wire        timer_a_output_one,
   input  wire        timer_b_output_zero,
   // conversion clock sources from other domains
   input  wire        internal_converter_osc,
   input  wire        aux_clock,
   input  wire        sub_main_clock,
   // analog core
   output wire        sample_hold,
   output wire        conv_start,
   output wire        conv_clk_en,
   output wire [3:0]  input_channel_select,
   output wire [2:0]  reference_select,
   input  wire        conv_done,
   input  wire [11:0] conv_result,
   // interrupt
   output wire        irq
);

   localparam [3:0] S_IDLE   = 4'b0001;
   localparam [3:0] S_WAIT   = 4'b0010;
   localparam [3:0] S_SAMPLE = 4'b0100;
   localparam [3:0] S_CONV   = 4'b1000;

   localparam [2:0] RG_CTL0   = 3'd0;
   localparam [2:0] RG_CTL1   = 3'd1;
   localparam [2:0] RG_FLAGS  = 3'd2;
   localparam [2:0] RG_MASK   = 3'd3;
   localparam [2:0] RG_SLOT   = 3'd4;
   localparam [2:0] RG_RESULT = 3'd5;
   localparam [2:0] RG_NONE   = 3'd7;

   localparam [7:0]  SLOT_BASE   = `OFS_SLOT_BASE;
   localparam [7:0]  RESULT_BASE = `OFS_RESULT_BASE;
   localparam [15:0] CTL1_RST    = `CTL1_RESET;

   function [2:0] region;
      input [7:0] a;
      begin
         if (a[1:0] != 2'b00) begin
            region = RG_NONE;
         end else if (a == `OFS_CTL0) begin
            region = RG_CTL0;
         end else if (a == `OFS_CTL1) begin
            region = RG_CTL1;
         end else if (a == `OFS_FLAGS) begin
            region = RG_FLAGS;
         end else if (a == `OFS_MASK) begin
            region = RG_MASK;
         end else if (a[7:6] == SLOT_BASE[7:6]) begin
            region = RG_SLOT;
         end else if (a[7:6] == RESULT_BASE[7:6]) begin
            region = RG_RESULT;
         end else begin
            region = RG_NONE;
         end
      end
   endfunction

   // registers
   reg [7:0]  ctl0_q;
   reg [15:1] ctl1_q;
   reg [15:0] flags_q;
   reg [15:0] flags_d;
   reg [15:0] mask_q;
   reg [7:0]  slot_ctl_q [0:15];
   reg [31:0] prdata_q;
   reg        pready_q;
   reg        pslverr_q;
   reg        irq_q;
   // synchronisers: {timer b, timer a, sub-main, aux, osc}
   reg [4:0]  sync1_q;
   reg [4:0]  sync2_q;
   reg [4:0]  sync3_q;
   reg        trig_q;
   reg [2:0]  div_cnt_q;
   // sequencer
   reg [3:0]  state_q;
   reg [3:0]  state_d;
   reg [3:0]  slot_q;
   reg [3:0]  slot_d;
   reg [3:0]  samp_cnt_q;
   reg        sample_hold_q;
   reg        conv_start_q;
   reg        conv_clk_en_q;
   reg [3:0]  chan_q;
   reg [2:0]  ref_q;
   reg        trig_raw;
   reg        src_edge;
   reg        start_taken;
   reg        seq_over;
   reg [3:0]  seq_next;
   integer    i;

   wire [11:0] mem_rdata;
   wire [2:0]  rg        = region(paddr);
   wire        setup     = psel & ~penable;
   wire        acc_first = psel & penable & ~pready_q;
   wire        xfer      = psel & penable & pready_q;
   wire        wr        = xfer & pwrite;
   wire        en        = ctl0_q[`CTL0_ENABLE];
   wire        multi_sample_mode       = ctl0_q[`CTL0_MSC];
   wire [1:0]  mode      = ctl1_q[`CTL1_MODE_HI:`CTL1_MODE_LO];
   wire [1:0]  csrc      = ctl1_q[`CTL1_CSRC_HI:`CTL1_CSRC_LO];
   wire [2:0]  div       = ctl1_q[`CTL1_DIV_HI:`CTL1_DIV_LO];
   wire [1:0]  tsrc      = ctl1_q[`CTL1_TSRC_HI:`CTL1_TSRC_LO];
   wire [3:0]  first     = ctl1_q[`CTL1_FIRST_HI:`CTL1_FIRST_LO];
   wire        pulse     = ctl1_q[`CTL1_PULSE];
   wire        busy      = ~state_q[0];
   wire        trig      = trig_raw ^ ctl1_q[`CTL1_INVERT];
   wire        trig_rise = trig & ~trig_q;
   wire        conv_tick = src_edge & (div_cnt_q == div);
   wire        store     = state_q[3] & conv_done;
   wire [7:0]  cur_ctl   = slot_ctl_q[slot_q];
   wire        mem_we    = store | (wr & (rg == RG_RESULT));
   wire [3:0]  mem_waddr = store ? slot_q : paddr[5:2];
   wire [11:0] mem_wdata = store ? conv_result : pwdata[11:0];

   result_store u_store (
      .mclk    (mclk),
      .nrst    (nrst),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .re      (setup),
      .raddr   (paddr[5:2]),
      .rdata_q (mem_rdata)
   );

   // two flip-flops before any use of a foreign-domain input
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
         sync3_q <= 5'h00;
      end else begin
         sync1_q <= {timer_b_output_zero, timer_a_output_one, sub_main_clock,
                     aux_clock, internal_converter_osc};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   always @* begin
      case (tsrc)
         `TSRC_SOFT:    trig_raw = ctl0_q[`CTL0_START];
         `TSRC_TIMER_A: trig_raw = sync2_q[3];
         `TSRC_TIMER_B: trig_raw = sync2_q[4];
         default:       trig_raw = 1'b0;
      endcase
   end

   // foreign clocks become rising-edge enables; limited to well under half of mclk
   always @* begin
      case (csrc)
         `CSRC_OSC:  src_edge = sync2_q[0] & ~sync3_q[0];
         `CSRC_AUX:  src_edge = sync2_q[1] & ~sync3_q[1];
         `CSRC_MAIN: src_edge = 1'b1;
         default:    src_edge = sync2_q[2] & ~sync3_q[2];
      endcase
   end

   // end-of-conversion decision per mode
   always @* begin
      seq_next = slot_q + 4'h1;
      case (mode)
         `MODE_SINGLE: begin
            seq_over = 1'b1;
         end
         `MODE_SEQ: begin
            seq_over = cur_ctl[`SLOT_EOS];
         end
         `MODE_REP_SINGLE: begin
            seq_over = ~en;
            seq_next = slot_q;
         end
         default: begin
            seq_over = ~en & cur_ctl[`SLOT_EOS];
            if (cur_ctl[`SLOT_EOS]) begin
               seq_next = first;
            end
         end
      endcase
   end

   always @* begin
      state_d     = state_q;
      slot_d      = slot_q;
      start_taken = 1'b0;
      case (state_q)
         S_IDLE: begin
            if (en && trig_rise) begin
               state_d     = S_SAMPLE;
               slot_d      = first;
               start_taken = 1'b1;
            end
         end
         S_WAIT: begin
            if (mode[1] && !en) begin
               state_d = S_IDLE;
            end else if (trig_rise) begin
               state_d     = S_SAMPLE;
               start_taken = 1'b1;
            end
         end
         S_SAMPLE: begin
            if (pulse ? (conv_tick && samp_cnt_q == `SAMPLE_TICKS - 4'h1) : !trig) begin
               state_d = S_CONV;
            end
         end
         S_CONV: begin
            if (conv_done) begin
               slot_d = seq_next;
               if (seq_over) begin
                  state_d = S_IDLE;
               end else if (multi_sample_mode) begin
                  state_d = S_SAMPLE;
               end else begin
                  state_d = S_WAIT;
               end
            end
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q       <= S_IDLE;
         slot_q        <= 4'h0;
         samp_cnt_q    <= 4'h0;
         trig_q        <= 1'b0;
         div_cnt_q     <= 3'h0;
         sample_hold_q <= 1'b0;
         conv_start_q  <= 1'b0;
         conv_clk_en_q <= 1'b0;
         chan_q        <= 4'h0;
         ref_q         <= 3'h0;
      end else begin
         state_q       <= state_d;
         slot_q        <= slot_d;
         trig_q        <= trig;
         conv_clk_en_q <= conv_tick;
         if (src_edge) begin
            div_cnt_q <= (div_cnt_q == div) ? 3'h0 : div_cnt_q + 3'h1;
         end
         if (state_d != S_SAMPLE) begin
            samp_cnt_q <= 4'h0;
         end else if (state_q[2] && conv_tick) begin
            samp_cnt_q <= samp_cnt_q + 4'h1;
         end
         sample_hold_q <= state_d[2];
         conv_start_q  <= state_q[2] & state_d[3];
         chan_q        <= slot_ctl_q[slot_d][`SLOT_CH_HI:`SLOT_CH_LO];
         ref_q         <= slot_ctl_q[slot_d][`SLOT_REF_HI:`SLOT_REF_LO];
      end
   end

   // configuration registers
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctl0_q <= `CTL0_RESET;
         ctl1_q <= CTL1_RST[15:1];
         mask_q <= 16'h0000;
         for (i = 0; i < 16; i = i + 1) begin
            slot_ctl_q[i] <= `SLOT_RESET;
         end
      end else begin
         if (start_taken || tsrc != `TSRC_SOFT) begin
            ctl0_q[`CTL0_START] <= 1'b0;
         end
         if (wr && rg == RG_CTL0) begin
            ctl0_q[`CTL0_ENABLE] <= pwdata[`CTL0_ENABLE];
            ctl0_q[`CTL0_MSC]    <= pwdata[`CTL0_MSC];
            if (pwdata[`CTL0_START]) begin
               ctl0_q[`CTL0_START] <= 1'b1;
            end
         end
         if (wr && rg == RG_CTL1 && !en) begin
            ctl1_q <= pwdata[15:1];
         end
         if (wr && rg == RG_MASK) begin
            mask_q <= pwdata[15:0];
         end
         if (wr && rg == RG_SLOT && !en) begin
            slot_ctl_q[paddr[5:2]] <= pwdata[7:0];
         end
      end
   end

   // result flags: a load in the same cycle as a clear keeps the flag set
   always @* begin
      flags_d = flags_q;
      if (wr && rg == RG_FLAGS) begin
         flags_d = flags_q & ~pwdata[15:0];
      end
      if (xfer && rg == RG_RESULT) begin
         flags_d[paddr[5:2]] = 1'b0;
      end
      if (store) begin
         flags_d[slot_q] = 1'b1;
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         flags_q   <= 16'h0000;
         irq_q     <= 1'b0;
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         flags_q  <= flags_d;
         irq_q    <= |(flags_d & mask_q);
         pready_q <= acc_first;
         if (acc_first) begin
            pslverr_q <= (rg == RG_NONE);
            case (rg)
               RG_CTL0:   prdata_q <= {24'h000000, ctl0_q};
               RG_CTL1:   prdata_q <= {16'h0000, ctl1_q, busy};
               RG_FLAGS:  prdata_q <= {16'h0000, flags_q};
               RG_MASK:   prdata_q <= {16'h0000, mask_q};
               RG_SLOT:   prdata_q <= {24'h000000, slot_ctl_q[paddr[5:2]]};
               RG_RESULT: prdata_q <= {20'h00000, mem_rdata};
               default:   prdata_q <= 32'h00000000;
            endcase
         end else if (xfer) begin
            pslverr_q <= 1'b0;
         end
      end
   end

   assign prdata               = prdata_q;
   assign pready               = pready_q;
   assign pslverr              = pslverr_q;
   assign irq                  = irq_q;
   assign sample_hold          = sample_hold_q;
   assign conv_start           = conv_start_q;
   assign conv_clk_en          = conv_clk_en_q;
   assign input_channel_select = chan_q;
   assign reference_select     = ref_q;

endmodule // sar_adc_sequence_control

//--- tb/sar_adc_sequence_control_sva.sv
// assertion checker on the converter control ports
module sar_adc_sequence_control_sva (
   // clock and reset
   input wire logic        mclk,
   input wire logic        nrst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // analog core
   input wire logic        sample_hold,
   input wire logic        conv_start
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
   property p_one_wait; psel && penable && !pready |=> pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready late");
   property p_rdy_access; pready |-> psel && penable; endproperty
   a_rdy_access: assert property (p_rdy_access) else $error("pready outside access");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
   property p_unmapped;
      pready && (paddr[1:0] != 2'h0 || (paddr >= 8'h10 && paddr < 8'h40)) |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error on hole");
   property p_result_zero;
      pready && !pwrite && paddr >= 8'h80 && paddr < 8'hC0 |-> prdata[31:12] == 20'h0;
   endproperty
   a_result_zero: assert property (p_result_zero) else $error("result upper bits set");
   property p_conv_follows; $fell(sample_hold) |-> conv_start; endproperty
   a_conv_follows: assert property (p_conv_follows) else $error("no start after sample");
   property p_start_pulse; conv_start |=> !conv_start ##1 !conv_start; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
   property p_start_idle; conv_start |-> !sample_hold; endproperty
   a_start_idle: assert property (p_start_idle) else $error("start while sampling");
endmodule // sar_adc_sequence_control_sva

bind sar_adc_sequence_control sar_adc_sequence_control_sva chk (
   .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sample_hold(sample_hold), .conv_start(conv_start));

//--- tb/sar_core_model.sv
// behavioural model of the analog successive-approximation core
module sar_core_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // control from the sequencer
   input  wire logic        conv_start,
   input  wire logic        conv_clk_en,
   input  wire logic [3:0]  input_channel_select,
   input  wire logic        slow,
   // answer
   output logic             conv_done,
   output logic [11:0]      conv_result
);
   timeunit 1ns;
   timeprecision 1ps;
   int         ticks_q;
   logic [3:0] ch_q;
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ticks_q <= 0;
         ch_q <= 4'h0;
         conv_done <= 1'b0;
         conv_result <= 12'h000;
      end else begin
         conv_done <= 1'b0;
         // result is only valid with done, so it churns otherwise
         conv_result <= ~conv_result;
         if (conv_start) begin
            ticks_q <= slow ? 20 : 12;
            ch_q <= input_channel_select;
         end else if (ticks_q != 0 && conv_clk_en) begin
            ticks_q <= ticks_q - 1;
            if (ticks_q == 1) begin
               conv_done <= 1'b1;
               conv_result <= {3{ch_q}};
            end
         end
      end
   end
endmodule // sar_core_model

//--- tb/tb_top.sv
// self-checking bench for the converter sequence control
`include "sar_adc_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
   logic        tma = 0, tmb = 0, osc = 0, aux = 0, sub = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, cfg;
   logic        pready, pslverr, sample_hold, conv_start, conv_clk_en, conv_done, irq;
   logic [3:0]  ch, c;
   logic [2:0]  ref_sel, d;
   logic [11:0] conv_result;
   logic [32:0] exp_q[$];
   int          n_errors = 0, compares = 0, cyc = 0;

   always #5 mclk = ~mclk;
   always #35 osc = ~osc;
   always #45 aux = ~aux;
   always #55 sub = ~sub;

   sar_adc_sequence_control uut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_a_output_one(tma), .timer_b_output_zero(tmb),
      .internal_converter_osc(osc), .aux_clock(aux), .sub_main_clock(sub),
      .sample_hold(sample_hold), .conv_start(conv_start), .conv_clk_en(conv_clk_en),
      .input_channel_select(ch), .reference_select(ref_sel), .conv_done(conv_done),
      .conv_result(conv_result), .irq(irq));
   sar_core_model core (.mclk(mclk), .nrst(nrst), .conv_start(conv_start),
      .conv_clk_en(conv_clk_en), .input_channel_select(ch), .slow(slow),
      .conv_done(conv_done), .conv_result(conv_result));

   task automatic end_of_test;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [32:0] seen, input logic [32:0] expv);
      compares++;
      if (seen !== expv) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wait_sig(input int k);
      int n;
      n = 0;
      while (((k == 0) ? irq : sample_hold) !== 1'b1 && n < 4000) begin
         @(posedge mclk);
         n++;
      end
      if (n == 4000) n_errors++;
   endtask
   task automatic irq_low;
      repeat (2) @(posedge mclk);
      check({32'h0, irq}, 33'h0);
   endtask

   // read answers are taken at the edge that samples pready
   always @(posedge mclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
         check({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h1_FFFF_FFFF);

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         end_of_test;
      end
   end

   initial begin
      void'($urandom(54));
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      rd(`OFS_CTL1, 33'h0);
      rd(8'h10, 33'h1_0000_0000);
      rd(8'h06, 33'h1_0000_0000);
      for (int i = 0; i < 4; i++) begin
         cfg = {16'h0, 4'(i * 3), 2'(i), 1'b1, 1'b0, 3'(i), 2'(i), 2'(i), 1'b1};
         apb(1'b1, `OFS_CTL1, cfg);
         rd(`OFS_CTL1, {1'b0, cfg & 32'hFFFF_FFFE});
      end
      apb(1'b1, `OFS_MASK, 32'h1);
      for (int i = 0; i < 4; i++) begin
         c = 4'($urandom_range(15));
         d = 3'($urandom_range(7));
         slow = i[0];
         cfg = {16'h0, 4'h0, 2'b00, 1'b1, 1'b0, d, 2'(i), 2'b00, 1'b0};
         apb(1'b1, `OFS_CTL0, 32'h0);
         apb(1'b1, `OFS_CTL1, cfg);
         apb(1'b1, `OFS_SLOT_BASE, {24'h0, 1'b0, d, c});
         apb(1'b1, `OFS_CTL0, 32'h3);
         wait_sig(1);
         check({30'h0, ref_sel}, {30'h0, d});
         check({29'h0, ch}, {29'h0, c});
         rd(`OFS_CTL1, {1'b0, cfg | 32'h1});
         wait_sig(0);
         rd(`OFS_CTL0, 33'h2);
         rd(`OFS_FLAGS, 33'h1);
         rd(`OFS_RESULT_BASE, {21'h0, {3{c}}});
         rd(`OFS_FLAGS, 33'h0);
         irq_low();
      end
      apb(1'b1, `OFS_CTL0, 32'h0);
      for (int s = 0; s < 3; s++)
         apb(1'b1, `OFS_SLOT_BASE + 8'(4 * s), {24'h0, s == 2, 3'h0, 4'(s + 5)});
      cfg = {16'h0, 4'h0, 2'b00, 1'b1, 1'b0, 3'h0, 2'b10, 2'b01, 1'b0};
      apb(1'b1, `OFS_CTL1, cfg);
      apb(1'b1, `OFS_MASK, 32'h4);
      apb(1'b1, `OFS_CTL0, 32'h83);
      apb(1'b1, `OFS_CTL1, 32'h0000_0F00);
      apb(1'b1, `OFS_SLOT_BASE, 32'h0);
      rd(`OFS_SLOT_BASE, 33'h5);
      wait_sig(0);
      rd(`OFS_CTL1, {1'b0, cfg});
      apb(1'b1, `OFS_MASK, 32'h0);
      irq_low();
      rd(`OFS_FLAGS, 33'h7);
      for (int s = 0; s < 3; s++)
         rd(`OFS_RESULT_BASE + 8'(4 * s), {21'h0, {3{4'(s + 5)}}});
      apb(1'b1, `OFS_CTL0, 32'h0);
      apb(1'b1, `OFS_MASK, 32'h1);
      // pin parked high so the inverted level starts low
      for (int s = 1; s < 3; s++) begin
         tma <= (s == 1);
         tmb <= (s == 2);
         cfg = {16'h0, 4'h0, 2'(s), 1'b0, 1'b1, 3'h0, 2'b10, 2'b00, 1'b0};
         apb(1'b1, `OFS_CTL1, cfg);
         apb(1'b1, `OFS_CTL0, 32'h2);
         repeat (40) @(posedge mclk);
         rd(`OFS_FLAGS, 33'h0);
         tma <= 1'b0;
         tmb <= 1'b0;
         wait_sig(1);
         // sampling lasts while the inverted pin is high; raising it ends it
         tma <= (s == 1);
         tmb <= (s == 2);
         wait_sig(0);
         rd(`OFS_FLAGS, 33'h1);
         apb(1'b1, `OFS_FLAGS, 32'h1);
         irq_low();
         apb(1'b1, `OFS_CTL0, 32'h0);
      end
      // repeat modes run on until enable drops, then finish the running pass
      for (int m = 2; m < 4; m++) begin
         cfg = {16'h0, 4'h0, 2'b00, 1'b1, 1'b0, 3'h0, 2'b10, 2'(m), 1'b0};
         apb(1'b1, `OFS_CTL1, cfg);
         apb(1'b1, `OFS_CTL0, 32'h83);
         wait_sig(0);
         apb(1'b1, `OFS_CTL0, 32'h80);
         repeat (150) @(posedge mclk);
         rd(`OFS_CTL1, {1'b0, cfg});
         rd(`OFS_RESULT_BASE, 33'h0_0000_0555);
      end
      apb(1'b1, `OFS_RESULT_BASE + 8'h3C, 32'hFFFF_FFFF);
      rd(`OFS_RESULT_BASE + 8'h3C, 33'h0_0000_0FFF);
      end_of_test();
   end
endmodule // tb_top
